// ==== include/ctc_pkg.sv ====
// What this block does
// - Three functions: maintenance, output test, functional test; tests need maintenance.
// - Maintenance setting off disables maintenance and all test controls, except while an assigned logic input is high.
// - Maintenance on with live outputs lets contacts energize normally.
// - Blocked-output maintenance ignores every output function; no contact closes.
// - With outputs blocked, LEDs including trip LED still follow protection.
// - Supervisory reporting continues and carries a maintenance-active indication.
// - Front-panel activation starts a 10 minute timer, then setting returns off.
// - Activation sources: logic input level, control command, front-panel setting.
// - Maintenance ends on input low, source withdrawn, or power loss.
// - Logic input held high keeps maintenance active without time limit.
// - Maintenance-active state is routable to any programmable LED.
// - Output test pattern has one bit per contact selecting closure.
// - Apply test closes selected contacts for contact test time, default 1.00s.
// - Functional test triggers one element; disabled element means no action.
// - End option 0 stops on trip command; option 1 holds for pulse time.
// - Functional test pulse length configurable, default 01.00s.
// - Tested stage sees test current twice its setting in all phases.
// - Untested stages keep evaluating field currents and remain able to trip.
// - Functional test of thermal replica resets thermal state to 0%.
// - Fault records hold measured field currents, never simulated test current.
package ctc_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned PANEL_TIMEOUT_MIN = 10;
  localparam int unsigned PANEL_TIMEOUT_MS = PANEL_TIMEOUT_MIN * 60 * 1000;
  localparam int unsigned CONTACT_TEST_MS_RESET = 1000;
  localparam int unsigned FUNC_TEST_MS_RESET = 1000;
  localparam int unsigned TIME_MS_W = 20;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MAINT_SET_OFF = 2'h0;
  localparam logic [1:0] MAINT_SET_LIVE = 2'h1;
  localparam logic [1:0] MAINT_SET_BLOCKED = 2'h2;
  localparam logic FUNC_END_TRIP = 1'h0;
  localparam logic FUNC_END_TIME = 1'h1;
  localparam logic [1:0] PROTO_MODBUS = 2'h0;
  localparam logic [1:0] PROTO_IEC103 = 2'h1;

  typedef enum logic [1:0] {
    CTC_MAINT_OFF,
    CTC_MAINT_LIVE,
    CTC_MAINT_BLOCKED
  } ctc_maint_t;

  typedef enum logic [1:0] {
    CTC_FT_IDLE,
    CTC_FT_RUN,
    CTC_FT_FINISH
  } ctc_ft_state_t;

endpackage

// ==== include/ctc_timer_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Start/stop handshake between the controller and its millisecond timer.
interface ctc_timer_if #(parameter int W = 20);
  logic start;
  logic stop;
  logic [W-1:0] limit_ms;
  logic running;
  logic done;
  modport ctl (output start, output stop, output limit_ms, input running, input done);
  modport tmr (input start, input stop, input limit_ms, output running, output done);
endinterface
`default_nettype wire

// ==== hw/ctc_ms_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctc_ms_timer #(
  parameter int W = 20
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tick_ms,
  ctc_timer_if.tmr t
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic run_reg;
  logic run_next;
  logic done_reg;
  logic done_next;

  always_comb
  begin
    count_next = count_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (t.stop)
    begin
      run_next = 1'b0;
    end
    else if (t.start)
    begin
      run_next = 1'b1;
      count_next = '0;
    end
    else if (run_reg && tick_ms)
    begin
      if (count_reg + W'(1) >= t.limit_ms)
      begin
        run_next = 1'b0;
        done_next = 1'b1;
      end
      count_next = count_reg + W'(1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      count_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign t.running = run_reg;
  assign t.done = done_reg;
endmodule // ctc_ms_timer
`default_nettype wire

// ==== hw/ctc_commissioning.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctc_commissioning #(
  parameter int NUM_CONTACTS = 7,
  parameter int NUM_ELEMENTS = 16,
  parameter int CUR_W = 16,
  parameter int THERM_W = 16,
  parameter int unsigned TICK_CYCLES = ctc_pkg::TICK_MS_CYCLES,
  parameter int unsigned PANEL_TIMEOUT_MS = ctc_pkg::PANEL_TIMEOUT_MS
) (
  input wire logic sys_clk,
  input wire logic reset,
  // Maintenance sources.
  input wire logic maint_input_pin,
  input wire logic maint_input_assigned,
  input wire logic [1:0] panel_setting,
  input wire logic panel_setting_write,
  input wire logic [1:0] rear_command,
  input wire logic rear_command_write,
  input wire logic [1:0] rear_protocol,
  output logic [1:0] panel_setting_now,
  output logic maint_active,
  output logic maintenance_outputs_blocked,
  output logic test_controls_visible,
  // Protection interface.
  input wire logic [NUM_CONTACTS-1:0] prot_contact_req,
  input wire logic [NUM_ELEMENTS-1:0] elem_enabled,
  input wire logic [NUM_ELEMENTS-1:0] elem_trip_cmd,
  input wire logic [CUR_W-1:0] elem_setting,
  input wire logic [CUR_W-1:0] field_current,
  input wire logic [NUM_ELEMENTS-1:0] elem_thermal,
  output logic [NUM_CONTACTS-1:0] contact_out,
  input wire logic [NUM_CONTACTS-1:0] prot_led_req,
  input wire logic trip_led_req,
  input wire logic [NUM_CONTACTS-1:0] led_maint_route,
  output logic [NUM_CONTACTS-1:0] led_out,
  output logic trip_led_out,
  output logic scada_maint_flag,
  // Output contact test.
  input wire logic [NUM_CONTACTS-1:0] test_pattern,
  input wire logic [ctc_pkg::TIME_MS_W-1:0] contact_test_ms,
  input wire logic output_test_apply,
  output logic output_test_busy,
  // Functional test.
  input wire logic [$clog2(NUM_ELEMENTS)-1:0] func_element,
  input wire logic func_end_option,
  input wire logic [ctc_pkg::TIME_MS_W-1:0] func_test_ms,
  input wire logic func_test_operate,
  output logic [NUM_ELEMENTS-1:0] elem_test_force,
  output logic [CUR_W-1:0] test_current,
  output logic [CUR_W-1:0] record_current,
  output logic thermal_reset,
  output logic func_test_busy
);

  // ---------------------------------------------------------------------------
  // Millisecond tick divider
  // ---------------------------------------------------------------------------
  logic [$clog2(TICK_CYCLES)-1:0] div_reg;
  logic [$clog2(TICK_CYCLES)-1:0] div_next;
  logic tick_ms;

  always_comb
  begin
    tick_ms = (div_reg == $bits(div_reg)'(TICK_CYCLES - 1));
    div_next = tick_ms ? '0 : div_reg + $bits(div_reg)'(1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      div_reg <= '0;
    else
      div_reg <= div_next;
  end

  // ---------------------------------------------------------------------------
  // Input synchroniser for the maintenance logic input
  // ---------------------------------------------------------------------------
  logic pin_meta_reg;
  logic pin_sync_reg;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= maint_input_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Maintenance mode selection
  // ---------------------------------------------------------------------------
  // The panel timeout counts in milliseconds so the counter stays small.
  logic [$clog2(PANEL_TIMEOUT_MS+1)-1:0] panel_ms_reg;
  logic [$clog2(PANEL_TIMEOUT_MS+1)-1:0] panel_ms_next;
  logic [1:0] panel_reg;
  logic [1:0] panel_next;
  logic [1:0] rear_reg;
  logic [1:0] rear_next;
  logic [1:0] mode_sel;
  logic input_on;

  always_comb
  begin
    panel_next = panel_reg;
    panel_ms_next = panel_ms_reg;
    rear_next = rear_reg;
    if (panel_setting_write)
    begin
      panel_next = panel_setting;
      panel_ms_next = '0;
    end
    else if (panel_reg != ctc_pkg::MAINT_SET_OFF && tick_ms)
    begin
      if (panel_ms_reg == $bits(panel_ms_reg)'(PANEL_TIMEOUT_MS - 1))
        panel_next = ctc_pkg::MAINT_SET_OFF;
      else
        panel_ms_next = panel_ms_reg + $bits(panel_ms_reg)'(1);
    end
    // Rear command only exists on the Modbus protocol.
    if (rear_command_write && rear_protocol == ctc_pkg::PROTO_MODBUS)
      rear_next = rear_command;
    if (rear_protocol != ctc_pkg::PROTO_MODBUS)
      rear_next = ctc_pkg::MAINT_SET_OFF;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      panel_reg <= ctc_pkg::MAINT_SET_OFF;
      panel_ms_reg <= '0;
      rear_reg <= ctc_pkg::MAINT_SET_OFF;
    end
    else
    begin
      panel_reg <= panel_next;
      panel_ms_reg <= panel_ms_next;
      rear_reg <= rear_next;
    end
  end

  // An assigned input high forces live maintenance with no time limit; a panel
  // or rear request for blocked outputs still wins the blocking choice.
  ctc_pkg::ctc_maint_t maint_state;

  always_comb
  begin
    input_on = maint_input_assigned && pin_sync_reg;
    mode_sel = panel_reg | rear_reg;
    if (mode_sel[1])
      maint_state = ctc_pkg::CTC_MAINT_BLOCKED;
    else if (mode_sel[0] || input_on)
      maint_state = ctc_pkg::CTC_MAINT_LIVE;
    else
      maint_state = ctc_pkg::CTC_MAINT_OFF;
  end

  assign panel_setting_now = panel_reg;
  assign maint_active = (maint_state != ctc_pkg::CTC_MAINT_OFF);
  assign maintenance_outputs_blocked = (maint_state == ctc_pkg::CTC_MAINT_BLOCKED);
  assign test_controls_visible = maint_active;
  assign scada_maint_flag = maint_active;

  // ---------------------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------------------
  ctc_timer_if #(.W(ctc_pkg::TIME_MS_W)) ot_if ();
  ctc_timer_if #(.W(ctc_pkg::TIME_MS_W)) ft_if ();

  ctc_ms_timer #(.W(ctc_pkg::TIME_MS_W)) u_out_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick_ms(tick_ms),
    .t(ot_if.tmr)
  );

  ctc_ms_timer #(.W(ctc_pkg::TIME_MS_W)) u_func_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick_ms(tick_ms),
    .t(ft_if.tmr)
  );

  // ---------------------------------------------------------------------------
  // Output contact test
  // ---------------------------------------------------------------------------
  logic [NUM_CONTACTS-1:0] ot_pattern_reg;
  logic [NUM_CONTACTS-1:0] ot_pattern_next;
  logic ot_accept;

  always_comb
  begin
    ot_accept = output_test_apply && maint_active && !ot_if.running;
    ot_pattern_next = ot_pattern_reg;
    if (ot_accept)
      ot_pattern_next = test_pattern;
    else if (ot_if.done || !maint_active)
      ot_pattern_next = '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ot_pattern_reg <= '0;
    else
      ot_pattern_reg <= ot_pattern_next;
  end

  assign ot_if.start = ot_accept;
  assign ot_if.stop = !maint_active;
  assign ot_if.limit_ms = contact_test_ms;
  assign output_test_busy = ot_if.running;

  // ---------------------------------------------------------------------------
  // Functional test
  // ---------------------------------------------------------------------------
  ctc_pkg::ctc_ft_state_t ft_state_reg;
  ctc_pkg::ctc_ft_state_t ft_state_next;
  logic [$clog2(NUM_ELEMENTS)-1:0] ft_elem_reg;
  logic [$clog2(NUM_ELEMENTS)-1:0] ft_elem_next;
  logic ft_end_reg;
  logic ft_end_next;
  logic ft_start;
  logic ft_stop;

  always_comb
  begin
    ft_state_next = ft_state_reg;
    ft_elem_next = ft_elem_reg;
    ft_end_next = ft_end_reg;
    ft_start = 1'b0;
    ft_stop = 1'b0;
    unique case (ft_state_reg)
      ctc_pkg::CTC_FT_IDLE:
      begin
        // A disabled element is a silent no-op.
        if (func_test_operate && maint_active && elem_enabled[func_element])
        begin
          ft_elem_next = func_element;
          ft_end_next = func_end_option;
          ft_start = 1'b1;
          ft_state_next = ctc_pkg::CTC_FT_RUN;
        end
      end
      ctc_pkg::CTC_FT_RUN:
      begin
        if (!maint_active)
        begin
          ft_stop = 1'b1;
          ft_state_next = ctc_pkg::CTC_FT_FINISH;
        end
        else if (ft_end_reg == ctc_pkg::FUNC_END_TRIP && elem_trip_cmd[ft_elem_reg])
        begin
          ft_stop = 1'b1;
          ft_state_next = ctc_pkg::CTC_FT_FINISH;
        end
        else if (ft_if.done)
          ft_state_next = ctc_pkg::CTC_FT_FINISH;
      end
      ctc_pkg::CTC_FT_FINISH:
        ft_state_next = ctc_pkg::CTC_FT_IDLE;
      default:
        ft_state_next = ctc_pkg::CTC_FT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ft_state_reg <= ctc_pkg::CTC_FT_IDLE;
      ft_elem_reg <= '0;
      ft_end_reg <= ctc_pkg::FUNC_END_TRIP;
    end
    else
    begin
      ft_state_reg <= ft_state_next;
      ft_elem_reg <= ft_elem_next;
      ft_end_reg <= ft_end_next;
    end
  end

  // In trip-end mode the pulse time still bounds the test so it cannot hang.
  assign ft_if.start = ft_start;
  assign ft_if.stop = ft_stop;
  assign ft_if.limit_ms = func_test_ms;
  assign func_test_busy = (ft_state_reg == ctc_pkg::CTC_FT_RUN);

  // ---------------------------------------------------------------------------
  // Test stimulus, records and thermal reset
  // ---------------------------------------------------------------------------
  logic [NUM_ELEMENTS-1:0] force_reg;
  logic [NUM_ELEMENTS-1:0] force_next;
  logic [CUR_W-1:0] test_cur_reg;
  logic [CUR_W-1:0] test_cur_next;
  logic [CUR_W-1:0] rec_cur_reg;
  logic therm_reg;
  logic therm_next;

  always_comb
  begin
    force_next = '0;
    if (ft_state_next == ctc_pkg::CTC_FT_RUN)
      force_next[ft_elem_next] = 1'b1;
    test_cur_next = (ft_state_next == ctc_pkg::CTC_FT_RUN) ?
      {elem_setting[CUR_W-2:0], 1'b0} : '0;
    therm_next = (ft_state_reg == ctc_pkg::CTC_FT_FINISH) && elem_thermal[ft_elem_reg];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      force_reg <= '0;
      test_cur_reg <= '0;
      rec_cur_reg <= '0;
      therm_reg <= 1'b0;
    end
    else
    begin
      force_reg <= force_next;
      test_cur_reg <= test_cur_next;
      rec_cur_reg <= field_current;
      therm_reg <= therm_next;
    end
  end

  assign elem_test_force = force_reg;
  assign test_current = test_cur_reg;
  assign record_current = rec_cur_reg;
  assign thermal_reset = therm_reg;

  // ---------------------------------------------------------------------------
  // Contact and LED outputs
  // ---------------------------------------------------------------------------
  logic [NUM_CONTACTS-1:0] contact_reg;
  logic [NUM_CONTACTS-1:0] contact_next;
  logic [NUM_CONTACTS-1:0] led_reg;
  logic [NUM_CONTACTS-1:0] led_next;
  logic trip_led_reg;

  always_comb
  begin
    if (maintenance_outputs_blocked)
      contact_next = '0;
    else
      contact_next = prot_contact_req | ot_pattern_reg;
    led_next = prot_led_req | (led_maint_route & {NUM_CONTACTS{maint_active}});
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      contact_reg <= '0;
      led_reg <= '0;
      trip_led_reg <= 1'b0;
    end
    else
    begin
      contact_reg <= contact_next;
      led_reg <= led_next;
      trip_led_reg <= trip_led_req;
    end
  end

  assign contact_out = contact_reg;
  assign led_out = led_reg;
  assign trip_led_out = trip_led_reg;

endmodule // ctc_commissioning
`default_nettype wire

// ==== verification/ctc_operator_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Front panel and rear link as the operator
// ----------------------------------------
module ctc_operator_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic go,
  input wire logic to_rear,
  input wire logic rogue,
  input wire logic [1:0] value,
  input wire logic [1:0] protocol,
  output logic [1:0] panel_setting,
  output logic panel_setting_write,
  output logic [1:0] rear_command,
  output logic rear_command_write
);
  logic [1:0] last_reg;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      last_reg <= 2'h0;
      panel_setting_write <= 1'h0;
      rear_command_write <= 1'h0;
    end
    else
    begin
      if (go)
        last_reg <= value;
      panel_setting_write <= go && !to_rear;
      rear_command_write <= go && to_rear && (protocol == ctc_pkg::PROTO_MODBUS || rogue);
    end
  end
  // Between writes the lines show the inverse, so a design reading them late sees junk.
  assign panel_setting = panel_setting_write ? last_reg : ~last_reg;
  assign rear_command = rear_command_write ? last_reg : ~last_reg;
endmodule // ctc_operator_model
`default_nettype wire

// ==== verification/ctc_commissioning_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctc_commissioning_checker #(
  parameter int NUM_CONTACTS = 7,
  parameter int NUM_ELEMENTS = 16,
  parameter int CUR_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic maint_active,
  input wire logic maintenance_outputs_blocked,
  input wire logic test_controls_visible,
  input wire logic scada_maint_flag,
  input wire logic [NUM_CONTACTS-1:0] prot_led_req,
  input wire logic trip_led_req,
  input wire logic [NUM_CONTACTS-1:0] led_maint_route,
  input wire logic [NUM_CONTACTS-1:0] led_out,
  input wire logic trip_led_out,
  input wire logic [NUM_CONTACTS-1:0] contact_out,
  input wire logic [NUM_CONTACTS-1:0] test_pattern,
  input wire logic output_test_apply,
  input wire logic output_test_busy,
  input wire logic func_end_option,
  input wire logic [NUM_ELEMENTS-1:0] elem_trip_cmd,
  input wire logic [NUM_ELEMENTS-1:0] elem_test_force,
  input wire logic [CUR_W-1:0] elem_setting,
  input wire logic [CUR_W-1:0] test_current,
  input wire logic [CUR_W-1:0] field_current,
  input wire logic [CUR_W-1:0] record_current,
  input wire logic thermal_reset,
  input wire logic func_test_busy
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [NUM_CONTACTS-1:0] led_want;
  assign led_want = prot_led_req | (led_maint_route & {NUM_CONTACTS{maint_active}});
  sequence s_apply_taken;
    output_test_apply && maint_active && !output_test_busy && !maintenance_outputs_blocked;
  endsequence
  sequence s_busy_then_closed;
    output_test_busy ##1 ((contact_out & $past(test_pattern, 2)) == $past(test_pattern, 2));
  endsequence
  a_apply_closes: assert property (s_apply_taken |=> s_busy_then_closed)
    else $error("apply did not close the selected contacts");
  a_tests_need_maint: assert property ($rose(output_test_busy) || $rose(func_test_busy) |-> $past(maint_active))
    else $error("test started without maintenance");
  a_blocked_silent: assert property (maintenance_outputs_blocked [*3] |-> contact_out == '0)
    else $error("contact closed while outputs blocked");
  a_controls_shown: assert property (test_controls_visible == maint_active)
    else $error("test controls visibility wrong");
  a_scada_flag: assert property (scada_maint_flag == maint_active)
    else $error("supervisory flag wrong");
  a_led_follow: assert property (!$past(reset) |-> led_out == $past(led_want) && trip_led_out == $past(trip_led_req))
    else $error("leds do not follow their sources");
  a_trip_ends: assert property (func_test_busy && func_end_option == ctc_pkg::FUNC_END_TRIP && |(elem_trip_cmd & elem_test_force) |-> ##[1:3] !func_test_busy)
    else $error("trip did not end the test");
  a_one_element: assert property ($onehot0(elem_test_force))
    else $error("more than one element forced");
  a_double_current: assert property (|elem_test_force && $stable(elem_setting) |-> test_current == CUR_W'({elem_setting, 1'b0}))
    else $error("test current not twice the setting");
  a_field_record: assert property (!$past(reset) |-> record_current == $past(field_current))
    else $error("record current not field current");
  a_thermal_pulse: assert property (thermal_reset |=> !thermal_reset)
    else $error("thermal reset longer than one cycle");
endmodule // ctc_commissioning_checker
bind ctc_commissioning ctc_commissioning_checker #(.NUM_CONTACTS(NUM_CONTACTS),
  .NUM_ELEMENTS(NUM_ELEMENTS), .CUR_W(CUR_W)) u_checker (.sys_clk, .reset, .maint_active,
  .maintenance_outputs_blocked, .test_controls_visible, .scada_maint_flag, .prot_led_req,
  .trip_led_req, .led_maint_route, .led_out, .trip_led_out, .contact_out, .test_pattern,
  .output_test_apply, .output_test_busy, .func_end_option, .elem_trip_cmd, .elem_test_force,
  .elem_setting, .test_current, .field_current, .record_current, .thermal_reset,
  .func_test_busy);
`default_nettype wire

// ==== verification/test_commissioning_test_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_commissioning_test_control;
  logic sys_clk, reset, maint_input_pin, maint_input_assigned, go, to_rear, rogue;
  logic panel_setting_write, rear_command_write, trip_led_req, trip_led_out;
  logic maint_active, maintenance_outputs_blocked, test_controls_visible, scada_maint_flag;
  logic output_test_apply, output_test_busy, func_end_option, func_test_operate;
  logic thermal_reset, func_test_busy;
  logic [1:0] panel_setting, rear_command, rear_protocol, panel_setting_now, value;
  logic [6:0] prot_contact_req, contact_out, prot_led_req, led_maint_route, led_out, test_pattern;
  logic [15:0] elem_enabled, elem_trip_cmd, elem_thermal, elem_test_force;
  logic [15:0] elem_setting, field_current, test_current, record_current;
  logic [19:0] contact_test_ms, func_test_ms;
  logic [3:0] func_element;
  int fail_count, comparisons, n;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  // Short tick and panel timeout keep the timed cases to a few dozen cycles.
  ctc_commissioning #(.TICK_CYCLES(4), .PANEL_TIMEOUT_MS(5)) dut (.*);
  ctc_operator_model model (.sys_clk, .reset, .go, .to_rear, .rogue, .value,
    .protocol(rear_protocol), .panel_setting, .panel_setting_write, .rear_command,
    .rear_command_write);
  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t value %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic operate(input logic rear, input logic [1:0] v);
    @(posedge sys_clk);
    go <= 1'h1;
    to_rear <= rear;
    value <= v;
    @(posedge sys_clk);
    go <= 1'h0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic strobe(input logic func);
    @(posedge sys_clk);
    if (func)
      func_test_operate <= 1'h1;
    else
      output_test_apply <= 1'h1;
    @(posedge sys_clk);
    func_test_operate <= 1'h0;
    output_test_apply <= 1'h0;
    @(negedge sys_clk);
  endtask
  task automatic give_up;
    fail_count++;
    final_report;
  endtask
  task automatic wait_maint(input logic v);
    for (n = 0; maint_active !== v; n++)
    begin
      if (n == 30)
        give_up;
      @(negedge sys_clk);
    end
  endtask
  task automatic busy_len(input logic func, output int k);
    k = 0;
    while ((func ? func_test_busy : output_test_busy) === 1'h1)
    begin
      @(negedge sys_clk);
      k++;
      if (k > 300)
        give_up;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_refused;
    check(maint_active, 1'h0);
    check(test_controls_visible, 1'h0);
    test_pattern <= 7'h7F;
    strobe(1'h0);
    strobe(1'h1);
    check(output_test_busy, 1'h0);
    check(func_test_busy, 1'h0);
    $display("refused test done");
  endtask
  task automatic t_panel;
    led_maint_route <= 7'h40;
    operate(1'h0, ctc_pkg::MAINT_SET_LIVE);
    check(maint_active, 1'h1);
    check(test_controls_visible, 1'h1);
    check(scada_maint_flag, 1'h1);
    check(led_out, 7'h40);
    wait_maint(1'h0);
    check(n >= 14 && n <= 18, 1'h1);
    check(panel_setting_now, 2'h0);
    check(maint_active, 1'h0);
    $display("panel timeout test done");
  endtask
  task automatic t_input;
    maint_input_assigned <= 1'h1;
    maint_input_pin <= 1'h1;
    wait_maint(1'h1);
    repeat (40) @(negedge sys_clk);
    check(maint_active, 1'h1);
    maint_input_pin <= 1'h0;
    wait_maint(1'h0);
    check(maint_active, 1'h0);
    $display("input level test done");
  endtask
  task automatic t_rear;
    operate(1'h1, ctc_pkg::MAINT_SET_BLOCKED);
    check(maintenance_outputs_blocked, 1'h1);
    prot_contact_req <= 7'h7F;
    prot_led_req <= 7'h05;
    trip_led_req <= 1'h1;
    repeat (3) @(negedge sys_clk);
    check(contact_out, 7'h00);
    check(led_out, 7'h45);
    check(trip_led_out, 1'h1);
    operate(1'h1, ctc_pkg::MAINT_SET_OFF);
    check(maint_active, 1'h0);
    check(contact_out, 7'h7F);
    rear_protocol <= ctc_pkg::PROTO_IEC103;
    rogue <= 1'h1;
    operate(1'h1, ctc_pkg::MAINT_SET_LIVE);
    check(maint_active, 1'h0);
    {rogue, trip_led_req, prot_contact_req, prot_led_req} <= '0;
    $display("rear command test done");
  endtask
  task automatic t_output;
    maint_input_pin <= 1'h1;
    prot_contact_req <= 7'h02;
    wait_maint(1'h1);
    repeat (2) @(negedge sys_clk);
    check(contact_out, 7'h02);
    prot_contact_req <= 7'h00;
    test_pattern <= 7'h55;
    contact_test_ms <= 20'h00003;
    @(negedge sys_clk);
    strobe(1'h0);
    check(output_test_busy, 1'h1);
    @(negedge sys_clk);
    check(contact_out, 7'h55);
    test_pattern <= 7'h2A;
    strobe(1'h0);
    check(contact_out, 7'h55);
    busy_len(1'h0, n);
    check(n >= 6 && n <= 9, 1'h1);
    repeat (2) @(negedge sys_clk);
    check(contact_out, 7'h00);
    $display("output test done");
  endtask
  task automatic t_func;
    logic seen;
    seen = 1'h0;
    elem_thermal <= 16'h0020;
    elem_setting <= 16'h0123;
    field_current <= 16'h0456;
    func_element <= 4'h3;
    func_end_option <= ctc_pkg::FUNC_END_TIME;
    func_test_ms <= 20'h00002;
    strobe(1'h1);
    @(negedge sys_clk);
    check(func_test_busy, 1'h1);
    check(elem_test_force, 16'h0008);
    check(test_current, 16'h0246);
    check(record_current, 16'h0456);
    busy_len(1'h1, n);
    check(n >= 5 && n <= 11, 1'h1);
    func_end_option <= ctc_pkg::FUNC_END_TRIP;
    func_test_ms <= 20'h00064;
    strobe(1'h1);
    elem_trip_cmd <= 16'h0008;
    repeat (4) @(negedge sys_clk);
    check(func_test_busy, 1'h0);
    elem_trip_cmd <= 16'h0000;
    func_element <= 4'h5;
    func_end_option <= ctc_pkg::FUNC_END_TIME;
    func_test_ms <= 20'h00002;
    strobe(1'h1);
    for (n = 0; n < 40; n++)
    begin
      @(negedge sys_clk);
      seen = seen | thermal_reset;
    end
    check(seen, 1'h1);
    func_element <= 4'h7;
    strobe(1'h1);
    check(func_test_busy, 1'h0);
    $display("functional test done");
  endtask
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    reset = 1'h1;
    {maint_input_pin, maint_input_assigned, go, to_rear, rogue, value, rear_protocol} = '0;
    {trip_led_req, output_test_apply, func_end_option, func_test_operate} = '0;
    {prot_contact_req, prot_led_req, led_maint_route, test_pattern, elem_trip_cmd} = '0;
    {elem_thermal, elem_setting, field_current, contact_test_ms, func_test_ms} = '0;
    elem_enabled = 16'h002A;
    func_element = 4'h1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'h0;
    @(negedge sys_clk);
    t_refused;
    t_panel;
    t_input;
    t_rear;
    t_output;
    t_func;
    final_report;
  end
endmodule // test_commissioning_test_control
`default_nettype wire
